/* core/vdfe_top.sv */
// control and front-end sequencing of the video decoder
`timescale 1ns/1ns
`default_nettype none
`include "vdfe_cfg.svh"
module vdfe_top
	import vdfe_pkg::*;
#(
	parameter int MUX_W = `VDFE_MUX_W
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             power_down_n,
	input  wire logic             address_select_strap,
	input  wire logic             serial_clock,
	input  wire logic             serial_data_line_in,
	output logic                  serial_data_line_out,
	output logic                  serial_data_line_oe,
	input  wire logic             diagnostic_sense_one,
	input  wire logic             diagnostic_sense_two,
	input  wire logic [9:0]       adc_sample,
	input  wire logic             adc_sample_valid,
	input  wire logic [7:0]       decoded_pixel,
	input  wire logic             decoded_valid,
	input  wire logic             decoded_hsync,
	input  wire logic             decoded_vsync,
	input  wire logic             decoded_field,
	input  wire logic [3:0]       video_events,
	output logic [MUX_W-1:0]      analog_video_inputs_sel,
	output logic [3:0]            sample_clock_mult,
	output logic [3:0]            oversample_ratio,
	output logic                  powered_down,
	output logic [9:0]            sd_decode_processor_sample,
	output logic                  sd_decode_processor_valid,
	output logic [7:0]            video_out,
	output logic                  video_out_valid,
	output logic                  hsync_out,
	output logic                  vsync_out,
	output logic                  field_out,
	output logic                  interrupt_request_out
);
	logic [1:0] pd_sync_q, scl_sync_q, sda_sync_q, strap_sync_q, d1_sync_q, d2_sync_q;
	logic       strap_q, run;
	logic [7:0] reg_addr, wr_data, rd_data;
	logic       wr_stb, sda_oe;
	logic [MUX_W-1:0] mux_q;
	vdfe_fmt_t  fmt_q;
	logic [3:0] irq_en_q, irq_st_q;
	logic [3:0] irq_clr;
	logic [7:0] status_word;
	logic       fmt_ok;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk) begin
		pd_sync_q    <= {pd_sync_q[0], power_down_n};
		scl_sync_q   <= {scl_sync_q[0], serial_clock};
		sda_sync_q   <= {sda_sync_q[0], serial_data_line_in};
		strap_sync_q <= {strap_sync_q[0], address_select_strap};
		d1_sync_q    <= {d1_sync_q[0], diagnostic_sense_one};
		d2_sync_q    <= {d2_sync_q[0], diagnostic_sense_two};
	end

	// strap caught while reset is held, kept afterwards
	// a strap moved after reset is ignored until the next reset
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_q <= strap_sync_q[1];
		end
	end

	// low power-down input halts the datapath
	assign run = pd_sync_q[1];
	always_ff @(posedge clk) begin
		powered_down <= rst ? 1'b0 : ~run;
	end

	////////////////////////////////////////////////////////////////////
	// serial configuration port
	// slave sees synchronised pins only, a few clocks behind the wire
	vdfe_serial_slave u_slave (
		.clk                  (clk),
		.rst                  (rst),
		.scl_s                (scl_sync_q[1]),
		.sda_s                (sda_sync_q[1]),
		.address_select_strap (strap_q),
		.rd_data              (rd_data),
		.sda_oe               (sda_oe),
		.reg_addr             (reg_addr),
		.wr_data              (wr_data),
		.wr_stb               (wr_stb)
	);

	// pin driven low only, open drain
	always_ff @(posedge clk) begin
		serial_data_line_out <= 1'b0;
		serial_data_line_oe  <= rst ? 1'b0 : sda_oe;
	end

	// only the three defined format codes are taken, others ignored
	assign fmt_ok = (wr_data[1:0] <= VDFE_FMT_COMPONENT);

	// writable configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			mux_q    <= '0;
			fmt_q    <= VDFE_FMT_COMPOSITE;
			irq_en_q <= 4'h0;
		end else if (wr_stb) begin
			case (reg_addr)
				`VDFE_REG_MUX:    mux_q <= wr_data[MUX_W-1:0];
				`VDFE_REG_FORMAT: begin
					if (fmt_ok) begin
						fmt_q <= vdfe_fmt_t'(wr_data[1:0]);
					end
				end
				`VDFE_REG_IRQ_EN: irq_en_q <= wr_data[3:0];
				default: ;
			endcase
		end
	end

	// status word: diag pins, power-down, sticky events
	assign status_word = {d2_sync_q[1], d1_sync_q[1], ~run, 1'b0, irq_st_q};

	// read back, status bits clear on a write of one, set wins
	always_comb begin
		case (reg_addr)
			`VDFE_REG_MUX:       rd_data = 8'(mux_q);
			`VDFE_REG_FORMAT:    rd_data = {6'h00, fmt_q};
			`VDFE_REG_IRQ_EN:    rd_data = {4'h0, irq_en_q};
			`VDFE_REG_STATUS:    rd_data = status_word;
			`VDFE_REG_SAMPLE:    rd_data = sd_decode_processor_sample[7:0];
			`VDFE_REG_SAMPLE_HI: rd_data = {6'h00, sd_decode_processor_sample[9:8]};
			default:             rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// sample clock multiple of the reference, held default in reset
	always_ff @(posedge clk) begin
		if (rst) begin
			sample_clock_mult <= `VDFE_MUL_COMPOSITE;
			oversample_ratio  <= `VDFE_OVERSAMPLE;
		end else begin
			oversample_ratio <= `VDFE_OVERSAMPLE;
			case (fmt_q)
				VDFE_FMT_SEPARATE:  sample_clock_mult <= `VDFE_MUL_SEPARATE;
				VDFE_FMT_COMPONENT: sample_clock_mult <= `VDFE_MUL_COMPONENT;
				default:            sample_clock_mult <= `VDFE_MUL_COMPOSITE;
			endcase
		end
	end

	// channel select out to the analog mux
	always_ff @(posedge clk) begin
		analog_video_inputs_sel <= rst ? '0 : mux_q;
	end

	// single 10-bit converter path to decoder
	always_ff @(posedge clk) begin
		if (rst) begin
			sd_decode_processor_sample <= 10'h000;
			sd_decode_processor_valid  <= 1'b0;
		end else begin
			sd_decode_processor_valid <= adc_sample_valid & run;
			if (adc_sample_valid && run) begin
				sd_decode_processor_sample <= adc_sample;
			end
		end
	end

	// 8-bit 4:2:2 stream with separate syncs
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			video_out       <= 8'h00;
			video_out_valid <= 1'b0;
			hsync_out       <= 1'b0;
			vsync_out       <= 1'b0;
			field_out       <= 1'b0;
		end else begin
			video_out       <= decoded_pixel;
			video_out_valid <= decoded_valid;
			hsync_out       <= decoded_hsync;
			vsync_out       <= decoded_vsync;
			field_out       <= decoded_field;
		end
	end

	////////////////////////////////////////////////////////////////////
	// write-one-to-clear mask, only on a status write
	assign irq_clr = (wr_stb && reg_addr == `VDFE_REG_STATUS) ? wr_data[3:0] : 4'h0;

	// sticky video events, write-one-to-clear, set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_st_q <= 4'h0;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | (video_events & {4{run}});
		end
	end

	// interrupt pin
	always_ff @(posedge clk) begin
		interrupt_request_out <= rst ? 1'b0 : |(irq_st_q & irq_en_q);
	end
endmodule : vdfe_top
`default_nettype wire

/* core/vdfe_cfg.svh */
// constants for the video decoder control front end
`ifndef VDFE_CFG_SVH
`define VDFE_CFG_SVH
`define VDFE_ADDR_STRAP0      7'h20
`define VDFE_ADDR_STRAP1      7'h21
`define VDFE_REF_KHZ          28636
`define VDFE_MUL_COMPOSITE    4'h2
`define VDFE_MUL_SEPARATE     4'h4
`define VDFE_MUL_COMPONENT    4'h6
`define VDFE_OVERSAMPLE       4'h4
`define VDFE_REG_MUX          8'h00
`define VDFE_REG_FORMAT       8'h01
`define VDFE_REG_IRQ_EN       8'h02
`define VDFE_REG_STATUS       8'h10
`define VDFE_REG_SAMPLE       8'h11
`define VDFE_REG_SAMPLE_HI    8'h12
`define VDFE_MUX_W            3
`define VDFE_BYTE_BITS        4'h8
`define VDFE_LAST_BIT         4'h7
`endif

/* core/vdfe_pkg.sv */
// types for the video decoder control front end
package vdfe_pkg;
	typedef enum logic [1:0] {
		VDFE_FMT_COMPOSITE = 2'h0,
		VDFE_FMT_SEPARATE  = 2'h1,
		VDFE_FMT_COMPONENT = 2'h2
	} vdfe_fmt_t;
	typedef enum logic [2:0] {
		VDFE_IDLE  = 3'h0,
		VDFE_ADDR  = 3'h1,
		VDFE_AACK  = 3'h3,
		VDFE_DATA  = 3'h2,
		VDFE_DACK  = 3'h6,
		VDFE_RDAT  = 3'h7,
		VDFE_RACK  = 3'h5,
		VDFE_SKIP  = 3'h4
	} vdfe_st_t;
endpackage : vdfe_pkg

/* core/vdfe_serial_slave.sv */
// two-wire serial configuration slave with strap-selected address
`timescale 1ns/1ns
`default_nettype none
`include "vdfe_cfg.svh"
module vdfe_serial_slave
	import vdfe_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       scl_s,
	input  wire logic       sda_s,
	input  wire logic       address_select_strap,
	input  wire logic [7:0] rd_data,
	output logic            sda_oe,
	output logic [7:0]      reg_addr,
	output logic [7:0]      wr_data,
	output logic            wr_stb
);
	vdfe_st_t   st_q;
	logic       scl_q, sda_q, first_q, rw_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [6:0] my_addr;
	logic       rise, fall, start, stop;

	assign rise  = scl_s & ~scl_q;
	assign fall  = ~scl_s & scl_q;
	assign start = scl_s & scl_q & sda_q & ~sda_s;
	assign stop  = scl_s & scl_q & ~sda_q & sda_s;
	// strap picks 0x40 or 0x42 write address
	assign my_addr = address_select_strap ? `VDFE_ADDR_STRAP1 : `VDFE_ADDR_STRAP0;

	// edge history
	always_ff @(posedge clk) begin
		scl_q <= rst ? 1'b1 : scl_s;
		sda_q <= rst ? 1'b1 : sda_s;
	end

	// protocol engine, reads and writes
	always_ff @(posedge clk) begin
		wr_stb <= 1'b0;
		if (rst || stop) begin
			st_q <= VDFE_IDLE;
			sda_oe <= 1'b0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			if (rst) begin
				reg_addr <= 8'h00;
				wr_data <= 8'h00;
			end
		end else if (start) begin
			st_q <= VDFE_ADDR;
			bit_q <= 4'h0;
			sda_oe <= 1'b0;
		end else begin
			case (st_q)
				VDFE_ADDR, VDFE_DATA: begin
					if (rise) begin
						sh_q <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
					end
					if (fall && bit_q == `VDFE_BYTE_BITS) begin
						bit_q <= 4'h0;
						if (st_q == VDFE_ADDR) begin
							if (sh_q[7:1] == my_addr) begin
								rw_q <= sh_q[0];
								first_q <= 1'b1;
								sda_oe <= 1'b1;
								st_q <= VDFE_AACK;
							end else begin
								st_q <= VDFE_SKIP;
							end
						end else begin
							sda_oe <= 1'b1;
							st_q <= VDFE_DACK;
							if (first_q) begin
								reg_addr <= sh_q;
							end else begin
								wr_data <= sh_q;
								wr_stb <= 1'b1;
							end
						end
					end
				end
				VDFE_AACK, VDFE_DACK: begin
					if (fall) begin
						if (st_q == VDFE_DACK && !first_q) begin
							reg_addr <= reg_addr + 8'h01;
						end
						first_q <= (st_q == VDFE_AACK) ? first_q : 1'b0;
						if (rw_q) begin
							sh_q <= rd_data;
							sda_oe <= ~rd_data[7];
							st_q <= VDFE_RDAT;
						end else begin
							sda_oe <= 1'b0;
							st_q <= VDFE_DATA;
						end
					end
				end
				VDFE_RDAT: begin
					if (fall) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == `VDFE_LAST_BIT) begin
							sda_oe <= 1'b0;
							st_q <= VDFE_RACK;
						end else begin
							sda_oe <= ~sh_q[6];
							sh_q <= {sh_q[6:0], 1'b0};
						end
					end
				end
				VDFE_RACK: begin
					if (rise) begin
						bit_q <= 4'h0;
						if (sda_s) begin
							st_q <= VDFE_SKIP;
						end else begin
							reg_addr <= reg_addr + 8'h01;
							st_q <= VDFE_AACK;
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule : vdfe_serial_slave
`default_nettype wire

/* verif/vdfe_host_model.sv */
// host controller model driving the two-wire configuration port
`timescale 1ns/1ns
`default_nettype none
module vdfe_host_model #(
	parameter int HALF = 40
)(
	input  wire logic clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_low
);
	// line released and clock high while idle
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// data falls while clock is high to open a frame
	task automatic start();
		sda_low = 1'b1;
		wt(HALF);
		scl = 1'b0;
	endtask : start
	// data moves mid low phase, sampled at end of high phase
	task automatic bit_io(input logic b, output logic s);
		wt(HALF / 2);
		sda_low = !b;
		wt(HALF / 2);
		scl = 1'b1;
		wt(HALF);
		s = sda_wire;
		scl = 1'b0;
	endtask : bit_io
	// eight bits msb first then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(last, ack);
		ack = !ack;
	endtask : xfer
	// data rises while clock is high to close the frame
	task automatic stop();
		wt(HALF / 2);
		sda_low = 1'b1;
		wt(HALF / 2);
		scl = 1'b1;
		wt(HALF);
		sda_low = 1'b0;
		wt(HALF);
	endtask : stop
endmodule : vdfe_host_model
`default_nettype wire

/* verif/vdfe_top_chk.sv */
// concurrent checks on the front end ports
`timescale 1ns/1ns
`default_nettype none
module vdfe_top_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       power_down_n,
	input wire logic [9:0] adc_sample,
	input wire logic       adc_sample_valid,
	input wire logic [7:0] decoded_pixel,
	input wire logic       decoded_valid,
	input wire logic [3:0] video_events,
	input wire logic [3:0] sample_clock_mult,
	input wire logic [3:0] oversample_ratio,
	input wire logic       powered_down,
	input wire logic [9:0] sd_decode_processor_sample,
	input wire logic       sd_decode_processor_valid,
	input wire logic [7:0] video_out,
	input wire logic       video_out_valid,
	input wire logic       interrupt_request_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reset_mult_a: assert property ($fell(rst) |-> sample_clock_mult == 4'h2)
		else $error("clock multiple not default after reset");
	over_four_a: assert property (oversample_ratio == 4'h4)
		else $error("oversample ratio not four");
	mult_legal_a: assert property (sample_clock_mult inside {4'h2, 4'h4, 4'h6})
		else $error("clock multiple outside the format set");
	pd_enter_a: assert property (!power_down_n [*4] |-> powered_down)
		else $error("power-down not entered");
	pd_leave_a: assert property (power_down_n [*4] |-> !powered_down)
		else $error("power-down not left");
	pd_quiet_a: assert property (!power_down_n [*4] |-> !video_out_valid && video_out == 8'h00)
		else $error("video moves in power-down");
	video_copy_a: assert property (power_down_n [*4] |->
		{video_out_valid, video_out} == $past({decoded_valid, decoded_pixel}))
		else $error("video stream not passed on");
	adc_copy_a: assert property (power_down_n [*4] |->
		sd_decode_processor_valid == $past(adc_sample_valid) && sd_decode_processor_sample ==
		($past(adc_sample_valid) ? $past(adc_sample) : $past(sd_decode_processor_sample)))
		else $error("converter word not passed on");
	irq_cause_a: assert property ($rose(interrupt_request_out) |-> $past(|video_events, 2))
		else $error("interrupt without a video event");
endmodule : vdfe_top_chk
bind vdfe_top vdfe_top_chk u_vdfe_top_chk (.clk, .rst, .power_down_n, .adc_sample,
	.adc_sample_valid, .decoded_pixel, .decoded_valid, .video_events, .sample_clock_mult,
	.oversample_ratio, .powered_down, .sd_decode_processor_sample,
	.sd_decode_processor_valid, .video_out, .video_out_valid, .interrupt_request_out);
`default_nettype wire

/* verif/vdfe_top_tb_top.sv */
// self-checking bench for the video decoder front end
`timescale 1ns/1ns
`default_nettype none
module vdfe_top_tb_top;
	logic       clk = '0, rst = '1, power_down_n = '1, address_select_strap = '0;
	logic       serial_clock, sda_low, serial_data_line_out, serial_data_line_oe;
	logic       diagnostic_sense_one = '0, diagnostic_sense_two = '0, adc_sample_valid = '0;
	logic       decoded_valid = '0, decoded_hsync = '0, decoded_vsync = '0, decoded_field = '0;
	logic [9:0] adc_sample = '0, sd_decode_processor_sample;
	logic [7:0] decoded_pixel = '0, video_out;
	logic [3:0] video_events = '0, sample_clock_mult, oversample_ratio;
	logic [2:0] analog_video_inputs_sel;
	logic       powered_down, sd_decode_processor_valid, video_out_valid, hsync_out;
	logic       vsync_out, field_out, interrupt_request_out;
	wire        serial_data_line_in = !(sda_low || (serial_data_line_oe && !serial_data_line_out));
	int         fail_count = 0, n_checks = 0;
	////////////////////////////////////////////////////////////////
	// clock, device and host
	always #20 clk = ~clk;
	vdfe_top u_vdfe_top (.clk, .rst, .power_down_n, .address_select_strap, .serial_clock,
		.serial_data_line_in, .serial_data_line_out, .serial_data_line_oe,
		.diagnostic_sense_one, .diagnostic_sense_two, .adc_sample, .adc_sample_valid,
		.decoded_pixel, .decoded_valid, .decoded_hsync, .decoded_vsync, .decoded_field,
		.video_events, .analog_video_inputs_sel, .sample_clock_mult, .oversample_ratio,
		.powered_down, .sd_decode_processor_sample, .sd_decode_processor_valid, .video_out,
		.video_out_valid, .hsync_out, .vsync_out, .field_out, .interrupt_request_out);
	vdfe_host_model u_vdfe_host_model (.clk, .sda_wire(serial_data_line_in),
		.scl(serial_clock), .sda_low);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic do_reset(input logic s);
		rst = 1'b1;
		address_select_strap = s;
		cyc(16);
		rst = 1'b0;
		cyc(4);
	endtask : do_reset
	// one register write; a reports the address acknowledge
	task automatic wr(input logic [7:0] dev, input logic [7:0] idx, input logic [7:0] dat,
		output logic a);
		logic [7:0] rx;
		logic       k;
		u_vdfe_host_model.start();
		u_vdfe_host_model.xfer(dev, 1'b1, rx, a);
		if (a) begin
			u_vdfe_host_model.xfer(idx, 1'b1, rx, k);
			u_vdfe_host_model.xfer(dat, 1'b1, rx, k);
		end
		u_vdfe_host_model.stop();
		cyc(4);
	endtask : wr
	// index write then a one-byte read ended by no-acknowledge
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		logic [7:0] rx;
		logic       k;
		u_vdfe_host_model.start();
		u_vdfe_host_model.xfer(8'h40, 1'b1, rx, k);
		u_vdfe_host_model.xfer(idx, 1'b1, rx, k);
		u_vdfe_host_model.stop();
		u_vdfe_host_model.start();
		u_vdfe_host_model.xfer(8'h41, 1'b1, rx, k);
		u_vdfe_host_model.xfer(8'hff, 1'b1, d, k);
		u_vdfe_host_model.stop();
	endtask : rd
	////////////////////////////////////////////////////////////////
	// opening reset and the defaults it leaves
	task automatic t_reset();
		cyc(16);
		rst = 1'b0;
		cyc(4);
		chk("mult", 16'h0002, 16'(sample_clock_mult));
		chk("ratio", 16'h0004, 16'(oversample_ratio));
	endtask : t_reset
	task automatic t_addr();
		logic a;
		wr(8'h42, 8'h00, 8'h01, a);
		chk("ack42", 16'h0000, 16'(a));
		wr(8'h40, 8'h00, 8'h05, a);
		chk("ack40", 16'h0001, 16'(a));
		chk("mux", 16'h0005, 16'(analog_video_inputs_sel));
		do_reset(1'b1);
		wr(8'h40, 8'h00, 8'h03, a);
		chk("ack40", 16'h0000, 16'(a));
		wr(8'h42, 8'h00, 8'h02, a);
		chk("ack42", 16'h0001, 16'(a));
		chk("mux", 16'h0002, 16'(analog_video_inputs_sel));
		do_reset(1'b0);
	endtask : t_addr
	task automatic t_fmt();
		logic       a;
		logic [7:0] d;
		logic [3:0] m [3] = '{4'h2, 4'h4, 4'h6};
		for (int f = 0; f < 3; f++) begin
			wr(8'h40, 8'h01, 8'(f), a);
			chk("mult", 16'(m[f]), 16'(sample_clock_mult));
		end
		wr(8'h40, 8'h01, 8'h03, a);
		chk("mult", 16'h0006, 16'(sample_clock_mult));
		rd(8'h01, d);
		chk("format", 16'h0002, 16'(d));
	endtask : t_fmt
	task automatic t_irq();
		logic a;
		wr(8'h40, 8'h02, 8'h01, a);
		video_events = 4'h2;
		cyc(1);
		video_events = 4'h0;
		cyc(3);
		chk("irq", 16'h0000, 16'(interrupt_request_out));
		video_events = 4'h1;
		cyc(1);
		video_events = 4'h0;
		cyc(3);
		chk("irq", 16'h0001, 16'(interrupt_request_out));
		wr(8'h40, 8'h10, 8'h01, a);
		chk("irq", 16'h0000, 16'(interrupt_request_out));
	endtask : t_irq
	task automatic t_stream();
		logic [7:0] d;
		decoded_pixel = 8'h5a;
		decoded_valid = 1'b1;
		decoded_hsync = 1'b1;
		decoded_field = 1'b1;
		diagnostic_sense_one = 1'b1;
		adc_sample = 10'h2a5;
		adc_sample_valid = 1'b1;
		cyc(1);
		chk("video", 16'h015a, 16'({video_out_valid, video_out}));
		chk("sync", 16'h0005, 16'({hsync_out, vsync_out, field_out}));
		chk("adc", 16'h06a5, 16'({sd_decode_processor_valid, sd_decode_processor_sample}));
		power_down_n = 1'b0;
		cyc(5);
		chk("pd", 16'h0001, 16'(powered_down));
		chk("video", 16'h0000, 16'({video_out_valid, video_out}));
		chk("sync", 16'h0000, 16'({hsync_out, vsync_out, field_out}));
		rd(8'h10, d);
		chk("status", 16'h0062, 16'(d));
		rd(8'h11, d);
		chk("sample", 16'h00a5, 16'(d));
		power_down_n = 1'b1;
		cyc(5);
		chk("pd", 16'h0000, 16'(powered_down));
	endtask : t_stream
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	// main sequence, starting with the opening reset
	initial begin
		t_reset();
		t_addr();
		t_fmt();
		t_irq();
		t_stream();
		final_report();
	end
	// watchdog: run needs about 30k clocks, limit at 75k
	initial begin
		#3_000_000;
		fail_count++;
		final_report();
	end
endmodule : vdfe_top_tb_top
`default_nettype wire
